/* File: gpio_alt_function_mux.sv */
`timescale 1ns/1ps
module gpio_alt_function_mux
   import gpio_mux_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic [31:0]               hrdata,
   input  wire logic [NUM_PINS-1:0]  pin_in,
   output logic [NUM_PINS-1:0]       pin_out,
   output logic [NUM_PINS-1:0]       pin_oe,
   output logic [NUM_PINS-1:0]       pin_pu,
   output logic [NUM_PINS-1:0]       pin_pd,
   output logic [NUM_PINS-1:0]       pin_analog,
   input  wire logic [SLOTS-1:0]     af_out,
   input  wire logic [SLOTS-1:0]     af_oe,
   output logic [SLOTS-1:0]          af_in,
   output logic                      swd_clk_in,
   output logic                      swd_dio_in,
   input  wire logic                 pd_mode,
   output logic                      slow_osc_on_bit,
   output logic                      slow_osc_bypass_bit,
   output logic [NUM_LINES-1:0]      ext_line,
   output logic                      wake_pulse,
   output logic                      pd_wake_pulse,
   output logic                      reset_pin_pull_up
);
   pin_mode_t       mode_q     [NUM_PINS];
   logic            otype_q    [NUM_PINS];
   logic [1:0]      pull_q     [NUM_PINS];
   logic [2:0]      af_q       [NUM_PINS];
   logic            latch_q    [NUM_PINS];
   pin_mode_t       eff_mode   [NUM_PINS];
   logic [NUM_PINS-1:0] s1_q, s2_q, s3_q;
   logic [NUM_PINS-1:0] wk_en_q, wk_rise_q;
   logic [4:0]      line_src_q [NUM_LINES];
   logic            wr_q;
   logic [11:0]     addr_q;
   logic [31:0]     rdata_d;
   logic            addr_ok;
   logic [NUM_PINS-1:0] out_d, oe_d, pu_d, pd_d, ana_d, edge_d;
   logic [SLOTS-1:0]    af_in_d;

   assign addr_ok   = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   // the reset pad is outside the pin array and always pulled up
   assign reset_pin_pull_up = 1'b1;

   function automatic int port_base(input logic portb);
      return portb ? PB0 : 0;
   endfunction : port_base

   function automatic int port_size(input logic portb);
      return portb ? NUM_B : NUM_A;
   endfunction : port_size

   // ---------------- bus address phase ----------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_q   <= 1'b0;
         addr_q <= 12'h000;
      end else begin
         wr_q   <= addr_ok && hwrite;
         addr_q <= haddr[11:0];
      end
   end

   always_comb begin
      int b;
      int n;
      b = port_base(haddr[PORTB_BIT]);
      n = port_size(haddr[PORTB_BIT]);
      rdata_d = 32'h0000_0000;
      if (haddr[SYS_BIT]) begin
         case (haddr[7:0])
            OFF_CTRL: begin
               rdata_d[CTRL_LSE_ON] = slow_osc_on_bit;
               rdata_d[CTRL_LSE_BP] = slow_osc_bypass_bit;
            end
            OFF_LINE0: rdata_d = {3'h0, line_src_q[3], 3'h0, line_src_q[2],
                                  3'h0, line_src_q[1], 3'h0, line_src_q[0]};
            OFF_LINE1: rdata_d = {3'h0, line_src_q[7], 3'h0, line_src_q[6],
                                  3'h0, line_src_q[5], 3'h0, line_src_q[4]};
            OFF_WKEN:   rdata_d[NUM_PINS-1:0] = wk_en_q;
            OFF_WKEDGE: rdata_d[NUM_PINS-1:0] = wk_rise_q;
            default: rdata_d = 32'h0000_0000;
         endcase
      end else begin
         for (int i = 0; i < NUM_B; i++) begin
            if (i < n) begin
               case (haddr[7:0])
                  OFF_MODE:  rdata_d[2*i +: 2] = mode_q[b+i];
                  OFF_OTYPE: rdata_d[i] = otype_q[b+i];
                  OFF_PULL:  rdata_d[2*i +: 2] = pull_q[b+i];
                  // analog pins read zero
                  OFF_IN:    rdata_d[i] = s2_q[b+i] && (eff_mode[b+i] != MODE_ANA);
                  OFF_LATCH: rdata_d[i] = latch_q[b+i];
                  OFF_AFLO:  if (i < 8) rdata_d[4*i +: 3] = af_q[b+i];
                  OFF_AFHI:  if (i >= 8) rdata_d[4*(i-8) +: 3] = af_q[b+i];
                  default: ;
               endcase
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_ok && !hwrite) begin
         hrdata <= rdata_d;
      end
   end

   // ---------------- pin configuration registers ----------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NUM_PINS; p++) begin
            mode_q[p]  <= rst_mode(p);
            pull_q[p]  <= rst_pull(p);
            otype_q[p] <= 1'b0;
            af_q[p]    <= AF_DEF;
         end
      end else if (wr_q && !addr_q[SYS_BIT]) begin
         for (int i = 0; i < NUM_B; i++) begin
            if (i < port_size(addr_q[PORTB_BIT])) begin
               case (addr_q[7:0])
                  OFF_MODE:  mode_q[port_base(addr_q[PORTB_BIT])+i] <=
                                pin_mode_t'(hwdata[2*i +: 2]);
                  OFF_OTYPE: otype_q[port_base(addr_q[PORTB_BIT])+i] <= hwdata[i];
                  OFF_PULL:  pull_q[port_base(addr_q[PORTB_BIT])+i] <= hwdata[2*i +: 2];
                  OFF_AFLO:  if (i < 8)
                                af_q[port_base(addr_q[PORTB_BIT])+i] <=
                                   hwdata[4*i +: 3];
                  OFF_AFHI:  if (i >= 8)
                                af_q[port_base(addr_q[PORTB_BIT])+i] <=
                                   hwdata[4*(i-8) +: 3];
                  default: ;
               endcase
            end
         end
      end
   end

   // set wins over clear when both land on one bit in the same word
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NUM_PINS; p++) begin
            latch_q[p] <= 1'b0;
         end
      end else if (wr_q && !addr_q[SYS_BIT]) begin
         for (int i = 0; i < NUM_B; i++) begin
            if (i < port_size(addr_q[PORTB_BIT])) begin
               case (addr_q[7:0])
                  OFF_LATCH:  latch_q[port_base(addr_q[PORTB_BIT])+i] <= hwdata[i];
                  OFF_SETCLR: if (hwdata[i])
                                 latch_q[port_base(addr_q[PORTB_BIT])+i] <= 1'b1;
                              else if (hwdata[CLR_SHIFT+i])
                                 latch_q[port_base(addr_q[PORTB_BIT])+i] <= 1'b0;
                  OFF_CLR:    if (hwdata[i])
                                 latch_q[port_base(addr_q[PORTB_BIT])+i] <= 1'b0;
                  default: ;
               endcase
            end
         end
      end
   end

   // ---------------- system-side registers ----------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slow_osc_on_bit     <= 1'b0;
         slow_osc_bypass_bit <= 1'b0;
         wk_en_q             <= '0;
         wk_rise_q           <= '0;
         for (int k = 0; k < NUM_LINES; k++) begin
            line_src_q[k] <= 5'h00;
         end
      end else if (wr_q && addr_q[SYS_BIT]) begin
         case (addr_q[7:0])
            OFF_CTRL: begin
               slow_osc_on_bit     <= hwdata[CTRL_LSE_ON];
               slow_osc_bypass_bit <= hwdata[CTRL_LSE_BP];
            end
            OFF_LINE0: for (int k = 0; k < 4; k++) line_src_q[k] <= hwdata[8*k +: 5];
            OFF_LINE1: for (int k = 0; k < 4; k++) line_src_q[k+4] <= hwdata[8*k +: 5];
            OFF_WKEN:   wk_en_q   <= hwdata[NUM_PINS-1:0];
            OFF_WKEDGE: wk_rise_q <= hwdata[NUM_PINS-1:0];
            default: ;
         endcase
      end
   end

   // ---------------- pin synchronisers ----------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // ---------------- per-pin pad control ----------------
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pad
         logic lse_force;
         // crystal holds both pins; bypass only needs the clock input pin
         assign lse_force = (g == PB8 || g == PB9) &&
                            (slow_osc_on_bit || pd_mode ||
                             (slow_osc_bypass_bit && g == PB8));
         assign eff_mode[g] = lse_force ? MODE_ANA : mode_q[g];

         always_comb begin
            logic af_bit;
            af_bit = af_out[slot(g, 0) + int'(af_q[g])];
            out_d[g] = 1'b0;
            oe_d[g]  = 1'b0;
            pu_d[g]  = (pull_q[g] == PULL_UP);
            pd_d[g]  = (pull_q[g] == PULL_DN);
            ana_d[g] = 1'b0;
            case (eff_mode[g])
               MODE_IN: ;
               MODE_OUT: begin
                  out_d[g] = latch_q[g];
                  oe_d[g]  = !otype_q[g] || !latch_q[g];
               end
               MODE_AF: begin
                  // the peripheral owns direction, the pin only adds open-drain
                  out_d[g] = af_bit;
                  oe_d[g]  = af_oe[slot(g, 0) + int'(af_q[g])] &&
                             (!otype_q[g] || !af_bit);
               end
               MODE_ANA: begin
                  pu_d[g]  = 1'b0;
                  pd_d[g]  = 1'b0;
                  ana_d[g] = 1'b1;
               end
               default: ;
            endcase
            edge_d[g] = wk_en_q[g] && (eff_mode[g] == MODE_IN) &&
                        (wk_rise_q[g] ? (s2_q[g] && !s3_q[g])
                                      : (!s2_q[g] && s3_q[g]));
         end

         for (genvar k = 0; k < NUM_AF; k++) begin : g_af
            assign af_in_d[slot(g, k)] =
               (eff_mode[g] == MODE_AF && af_q[g] == 3'(k)) ? s2_q[g]
                                                             : IDLE_HIGH[slot(g, k)];
         end
      end
   endgenerate

   // registered pad stage costs one cycle but keeps pad timing clean
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_out    <= '0;
         pin_oe     <= '0;
         pin_pu     <= '0;
         pin_pd     <= '0;
         pin_analog <= '1;
         af_in      <= IDLE_HIGH;
      end else begin
         pin_out    <= out_d;
         pin_oe     <= oe_d;
         pin_pu     <= pu_d;
         pin_pd     <= pd_d;
         pin_analog <= ana_d;
         af_in      <= af_in_d;
      end
   end

   // debug inputs take the selected candidate pin, PA4 or PA5 ahead of PB6 or PB7, else their idle level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         swd_clk_in <= 1'b0;
         swd_dio_in <= 1'b1;
      end else begin
         swd_clk_in <= (eff_mode[PA4] == MODE_AF && af_q[PA4] == 3'h0) ? s2_q[PA4] :
                       (eff_mode[PB6] == MODE_AF && af_q[PB6] == 3'h6) ? s2_q[PB6] :
                       1'b0;
         swd_dio_in <= (eff_mode[PA5] == MODE_AF && af_q[PA5] == 3'h0) ? s2_q[PA5] :
                       (eff_mode[PB7] == MODE_AF && af_q[PB7] == 3'h6) ? s2_q[PB7] :
                       1'b1;
      end
   end

   // ---------------- event lines and wake-up ----------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_line      <= '0;
         wake_pulse    <= 1'b0;
         pd_wake_pulse <= 1'b0;
      end else begin
         for (int k = 0; k < NUM_LINES; k++) begin
            // a line only follows a pin that software left in input mode
            ext_line[k] <= (int'(line_src_q[k]) < NUM_PINS) &&
                           (eff_mode[line_src_q[k]] == MODE_IN) &&
                           s2_q[line_src_q[k]];
         end
         wake_pulse    <= |edge_d;
         pd_wake_pulse <= edge_d[PB3];
      end
   end

   // ---------------- checks ----------------
   sequence s_set_write;
      wr_q && !addr_q[SYS_BIT] && !addr_q[PORTB_BIT] && addr_q[7:0] == OFF_SETCLR;
   endsequence

   a_reset_analog: assert property (@(posedge clk) $fell(rst) |->
      mode_q[0] == MODE_ANA && pin_analog[0] && !pin_oe[0])
      else $error("pin not analog after reset");
   a_reset_selector: assert property (@(posedge clk) $fell(rst) |->
      af_q[PB7] == AF_DEF && af_q[PA4] == AF_DEF)
      else $error("selector not at default after reset");
   a_swd_clk_def: assert property (@(posedge clk) $fell(rst) |->
      mode_q[PA4] == MODE_AF && pull_q[PA4] == PULL_DN)
      else $error("debug clock pin default wrong");
   a_swd_dio_def: assert property (@(posedge clk) $fell(rst) |->
      mode_q[PA5] == MODE_AF && pull_q[PA5] == PULL_UP)
      else $error("debug data pin default wrong");
   a_bit_set: assert property (@(posedge clk) disable iff (rst)
      s_set_write ##0 hwdata[0] |=> latch_q[0])
      else $error("set bit did not set latch");
   a_bit_keep: assert property (@(posedge clk) disable iff (rst)
      s_set_write ##0 !hwdata[1] && !hwdata[CLR_SHIFT+1]
      |=> latch_q[1] == $past(latch_q[1]))
      else $error("unwritten bit changed");
   a_analog_quiet: assert property (@(posedge clk) disable iff (rst)
      eff_mode[PB0] == MODE_ANA |=> !pin_oe[PB0] && !pin_pu[PB0] && !pin_pd[PB0])
      else $error("analog pin still driven or pulled");
   a_af_route: assert property (@(posedge clk) disable iff (rst)
      eff_mode[PB0+4] == MODE_AF |=>
      pin_out[PB0+4] == $past(af_out[slot(PB0+4, 0) + int'(af_q[PB0+4])]))
      else $error("alternate output not routed");
   a_lse_force: assert property (@(posedge clk) disable iff (rst)
      slow_osc_on_bit |=> pin_analog[PB8] && pin_analog[PB9])
      else $error("crystal pins not analog");
   a_pd_wake_src: assert property (@(posedge clk) disable iff (rst)
      pd_wake_pulse |-> $past(wk_en_q[PB3]) && wake_pulse)
      else $error("power-down wake without enabled PB3");
endmodule : gpio_alt_function_mux

/* File: gpio_alt_function_mux_test.sv */
`timescale 1ns/1ps
module gpio_alt_function_mux_test
   import gpio_mux_pkg::*;
;
   localparam int T_PB4 = (PB0 + 4) * NUM_AF;
   logic                 clk, rst, hsel, hwrite, hready, hreadyout, hresp, pd_mode;
   logic [31:0]          haddr, hwdata, hrdata;
   logic [1:0]           htrans;
   logic [2:0]           hsize;
   logic [NUM_PINS-1:0]  pin_in, pin_out, pin_oe, pin_pu, pin_pd, pin_analog, ext_drv, ext_lvl;
   logic [SLOTS-1:0]     af_out, af_oe, af_in;
   logic                 swd_clk_in, swd_dio_in, slow_osc_on_bit, slow_osc_bypass_bit;
   logic                 wake_pulse, pd_wake_pulse, reset_pin_pull_up, w, p;
   logic [NUM_LINES-1:0] ext_line;
   int                   err_count, comparisons;

   gpio_alt_function_mux gpio_alt_function_mux_inst (.clk, .rst, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pin_in, .pin_out,
      .pin_oe, .pin_pu, .pin_pd, .pin_analog, .af_out, .af_oe, .af_in, .swd_clk_in,
      .swd_dio_in, .pd_mode, .slow_osc_on_bit, .slow_osc_bypass_bit, .ext_line, .wake_pulse,
      .pd_wake_pulse, .reset_pin_pull_up);
   gpio_far_side gpio_far_side_inst (.clk, .pin_out, .pin_oe, .pin_pu, .pin_pd, .ext_drv,
      .ext_lvl, .pin_in);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic wrap_up();
      $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // hreadyout is sampled at each edge; a slave that never answers ends the run
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 40);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 80);
      rd = hrdata;
      if (n >= 80) begin
         err_count++;
         wrap_up();
      end
   endtask : bus

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] v;
      bus(1'b1, a, d, v);
   endtask : wr

   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] v;
      bus(1'b0, a, 32'h0, v);
      chk(v, exp);
      chk(hresp, 0);
   endtask : rdchk

   task automatic catch_wake();
      w = 1'b0;
      p = 1'b0;
      for (int n = 0; n < 10 && !w; n++) begin
         tick(1);
         if (wake_pulse === 1'b1) begin
            w = 1'b1;
            p = pd_wake_pulse;
         end
      end
   endtask : catch_wake

   task automatic t_reset();
      chk(reset_pin_pull_up, 1);
      chk(hreadyout, 1);
      chk(pin_analog, 32'h1fffcf);
      chk(pin_pd[PA4], 1);
      chk(pin_pu[PA5], 1);
      rdchk(32'h000, 32'h0000_3aff);
      rdchk(32'h400, 32'h0fff_ffff);
      rdchk(32'h00c, 32'h0000_0600);
      rdchk(32'h020, 32'h0);
      rdchk(32'h424, 32'h0);
      @(posedge clk);
      ext_drv[PA4] <= 1'b1;
      ext_lvl[PA4] <= 1'b1;
      tick(4);
      chk(swd_clk_in, 1);
      chk(swd_dio_in, 1);
      $display("reset test done");
   endtask : t_reset

   task automatic t_setclr();
      wr(32'h000, 32'h0000_3afd);
      wr(32'h018, 32'h0000_0005);
      rdchk(32'h014, 32'h5);
      wr(32'h018, 32'h0001_0002);
      rdchk(32'h014, 32'h6);
      wr(32'h028, 32'h0000_0004);
      rdchk(32'h014, 32'h2);
      wr(32'h018, 32'h0000_0001);
      tick(2);
      chk({pin_oe[0], pin_out[0]}, 2'b11);
      wr(32'h014, 32'hffff_ffff);
      rdchk(32'h014, 32'h7f);
      $display("set clear test done");
   endtask : t_setclr

   task automatic t_af();
      wr(32'h400, 32'h0fff_feff);
      @(posedge clk);
      af_oe[T_PB4+:8] <= 8'hff;
      af_out[T_PB4+:8] <= 8'h5a;
      for (int k = 0; k < NUM_AF; k++) begin
         wr(32'h420, 32'(k) << 16);
         tick(2);
         chk(pin_out[PB0+4], 8'h5a >> k & 1);
      end
      wr(32'h420, 32'h0002_0000);
      @(posedge clk);
      af_oe[T_PB4+2] <= 1'b0;
      ext_drv[PB0+4] <= 1'b1;
      ext_lvl[PB0+4] <= 1'b1;
      tick(4);
      chk(pin_oe[PB0+4], 0);
      chk(af_in[T_PB4+2], 1);
      chk(af_in[T_PB4+3], 0);
      $display("alternate function test done");
   endtask : t_af

   task automatic t_analog();
      @(posedge clk);
      ext_drv[1] <= 1'b1;
      ext_lvl[1] <= 1'b1;
      tick(4);
      rdchk(32'h010, 32'h31);
      chk(pin_pu[1] | pin_oe[1], 0);
      $display("analog test done");
   endtask : t_analog

   task automatic t_osc();
      wr(32'h400, 32'h0ff0_feff);
      tick(2);
      chk(pin_analog[PB9:PB8], 2'b00);
      wr(32'h800, 32'h1);
      tick(2);
      chk(pin_analog[PB9:PB8], 2'b11);
      chk(slow_osc_on_bit, 1);
      wr(32'h800, 32'h2);
      tick(2);
      chk(pin_analog[PB9:PB8], 2'b01);
      chk(slow_osc_bypass_bit, 1);
      wr(32'h800, 32'h0);
      @(posedge clk);
      pd_mode <= 1'b1;
      tick(2);
      chk(pin_analog[PB9:PB8], 2'b11);
      @(posedge clk);
      pd_mode <= 1'b0;
      $display("slow oscillator test done");
   endtask : t_osc

   task automatic t_wake();
      @(posedge clk);
      ext_drv[2] <= 1'b1;
      ext_lvl[2] <= 1'b1;
      ext_drv[PB3] <= 1'b1;
      wr(32'h000, 32'h0000_3acd);
      wr(32'h400, 32'h0ff0_fe3f);
      wr(32'h808, 32'h2);
      wr(32'h810, 32'h0000_0404);
      wr(32'h814, 32'h0000_0400);
      tick(4);
      chk(ext_line[0], 1);
      @(posedge clk);
      ext_lvl[PB3] <= 1'b1;
      catch_wake();
      chk({w, p}, 2'b11);
      @(posedge clk);
      ext_lvl[2] <= 1'b0;
      catch_wake();
      chk({w, p}, 2'b10);
      chk(ext_line[0], 0);
      rdchk(32'h03c, 32'h0);
      $display("wake test done");
   endtask : t_wake

   task automatic t_remap();
      @(posedge clk);
      ext_drv[PB6] <= 1'b1;
      ext_lvl[PB6] <= 1'b0;
      wr(32'h000, 32'h0000_38cd);
      wr(32'h400, 32'h0ff0_ee3f);
      wr(32'h420, 32'h0602_0000);
      tick(4);
      chk(swd_clk_in, 0);
      @(posedge clk);
      ext_lvl[PB6] <= 1'b1;
      tick(4);
      chk(swd_clk_in, 1);
      wr(32'h404, 32'h0000_0010);
      @(posedge clk);
      af_oe[T_PB4+2] <= 1'b1;
      af_out[T_PB4+2] <= 1'b1;
      tick(2);
      chk(pin_oe[PB0+4], 0);
      @(posedge clk);
      af_out[T_PB4+2] <= 1'b0;
      tick(2);
      chk(pin_oe[PB0+4], 1);
      wr(32'h424, 32'h0000_0003);
      rdchk(32'h424, 32'h3);
      $display("remap test done");
   endtask : t_remap

   task automatic t_rerun();
      @(posedge clk);
      rst <= 1'b1;
      tick(2);
      @(posedge clk);
      rst <= 1'b0;
      tick(2);
      chk(pin_analog, 32'h1fffcf);
      rdchk(32'h000, 32'h0000_3aff);
      rdchk(32'h420, 32'h0);
      rdchk(32'h424, 32'h0);
      rdchk(32'h404, 32'h0);
      $display("second reset test done");
   endtask : t_rerun

   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = '0;
      hready = 1'b1;
      pd_mode = 1'b0;
      ext_drv = '0;
      ext_lvl = '0;
      af_out = '0;
      af_oe = '0;
      err_count = 0;
      comparisons = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      tick(2);
      t_reset();
      t_setclr();
      t_af();
      t_analog();
      t_osc();
      t_wake();
      t_remap();
      t_rerun();
      wrap_up();
   end
endmodule : gpio_alt_function_mux_test

/* File: gpio_far_side.sv */
`timescale 1ns/1ps
module gpio_far_side
   import gpio_mux_pkg::*;
(
   input  wire logic                clk,
   input  wire logic [NUM_PINS-1:0] pin_out,
   input  wire logic [NUM_PINS-1:0] pin_oe,
   input  wire logic [NUM_PINS-1:0] pin_pu,
   input  wire logic [NUM_PINS-1:0] pin_pd,
   input  wire logic [NUM_PINS-1:0] ext_drv,
   input  wire logic [NUM_PINS-1:0] ext_lvl,
   output logic      [NUM_PINS-1:0] pin_in
);
   logic wobble_q = 1'b0;
   // a floating pad wanders so that a stale level never passes as a real one
   always_ff @(posedge clk) begin
      wobble_q <= ~wobble_q;
   end
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_drv[i] ? ext_lvl[i] :
                     pin_pu[i] ? 1'b1 : pin_pd[i] ? 1'b0 : wobble_q;
      end
   end
endmodule : gpio_far_side

/* File: gpio_mux_pkg.sv */
package gpio_mux_pkg;
   localparam int NUM_A     = 7;
   localparam int NUM_B     = 14;
   localparam int NUM_PINS  = NUM_A + NUM_B;
   localparam int NUM_AF    = 8;
   localparam int NUM_LINES = 8;
   localparam int SLOTS     = NUM_PINS * NUM_AF;
   localparam int PB0       = NUM_A;
   localparam int PA4       = 4;
   localparam int PA5       = 5;
   localparam int PB3       = PB0 + 3;
   localparam int PB6       = PB0 + 6;
   localparam int PB7       = PB0 + 7;
   localparam int PB8       = PB0 + 8;
   localparam int PB9       = PB0 + 9;

   localparam logic [7:0] OFF_MODE   = 8'h00;
   localparam logic [7:0] OFF_OTYPE  = 8'h04;
   localparam logic [7:0] OFF_PULL   = 8'h0c;
   localparam logic [7:0] OFF_IN     = 8'h10;
   localparam logic [7:0] OFF_LATCH  = 8'h14;
   localparam logic [7:0] OFF_SETCLR = 8'h18;
   localparam logic [7:0] OFF_AFLO   = 8'h20;
   localparam logic [7:0] OFF_AFHI   = 8'h24;
   localparam logic [7:0] OFF_CLR    = 8'h28;
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_LINE0  = 8'h08;
   localparam logic [7:0] OFF_LINE1  = 8'h0c;
   localparam logic [7:0] OFF_WKEN   = 8'h10;
   localparam logic [7:0] OFF_WKEDGE = 8'h14;
   localparam int PORTB_BIT = 10;
   localparam int SYS_BIT   = 11;
   localparam int CTRL_LSE_ON = 0;
   localparam int CTRL_LSE_BP = 1;
   localparam int CLR_SHIFT   = 16;

   typedef enum logic [1:0] {
      MODE_IN  = 2'b00,
      MODE_OUT = 2'b01,
      MODE_AF  = 2'b10,
      MODE_ANA = 2'b11
   } pin_mode_t;
   localparam logic [1:0] PULL_NONE = 2'b00;
   localparam logic [1:0] PULL_UP   = 2'b01;
   localparam logic [1:0] PULL_DN   = 2'b10;
   localparam logic [2:0] AF_DEF    = 3'h0;

   function automatic int slot(input int pin, input int af);
      return pin * NUM_AF + af;
   endfunction : slot

   // debug pins come up in alternate mode so a probe can attach at once
   function automatic pin_mode_t rst_mode(input int p);
      return (p == PA4 || p == PA5) ? MODE_AF : MODE_ANA;
   endfunction : rst_mode

   function automatic logic [1:0] rst_pull(input int p);
      return (p == PA4) ? PULL_DN : (p == PA5) ? PULL_UP : PULL_NONE;
   endfunction : rst_pull

   // inputs that idle high: debug data, serial receive and clear-to-send, bus lines
   function automatic logic [SLOTS-1:0] idle_high_mask();
      logic [SLOTS-1:0] m;
      m = '0;
      m[slot(PA5, 0)]      = 1'b1;
      m[slot(PB7, 6)]      = 1'b1;
      m[slot(PA5, 3)]      = 1'b1;
      m[slot(PB7, 4)]      = 1'b1;
      m[slot(PB0 + 1, 3)]  = 1'b1;
      m[slot(PB9, 3)]      = 1'b1;
      m[slot(PB0 + 5, 3)]  = 1'b1;
      m[slot(PB0 + 10, 3)] = 1'b1;
      m[slot(PB0 + 12, 3)] = 1'b1;
      m[slot(PB0 + 11, 2)] = 1'b1;
      m[slot(PB0 + 2, 4)]  = 1'b1;
      m[slot(PB0 + 13, 2)] = 1'b1;
      m[slot(PB3, 4)]      = 1'b1;
      m[slot(PB7, 3)]      = 1'b1;
      m[slot(PB9, 2)]      = 1'b1;
      m[slot(PB6, 3)]      = 1'b1;
      m[slot(PB8, 2)]      = 1'b1;
      return m;
   endfunction : idle_high_mask
   localparam logic [SLOTS-1:0] IDLE_HIGH = idle_high_mask();
endpackage : gpio_mux_pkg
